//--- design/rao_pkg.sv
// package for the register alu move operations block
package rao_pkg;
   localparam int unsigned DATA_W = 8;
   localparam int unsigned ADDR_W = 7;
   localparam int unsigned NUM_REGS = 128;
   localparam logic [2:0] OPC_RMW = 3'h7;
   localparam logic [2:0] OPC_TO_SCR = 3'h6;
   localparam logic [2:0] OPC_FROM_SCR = 3'h5;
   localparam logic [2:0] OP_LOAD = 3'h0;
   localparam logic [2:0] OP_SHL = 3'h1;
   localparam logic [2:0] OP_OR = 3'h2;
   localparam logic [2:0] OP_XOR = 3'h3;
   localparam logic [2:0] OP_AND = 3'h4;
   localparam logic [2:0] OP_SHR = 3'h5;
   localparam logic [2:0] OP_ADD = 3'h6;
   localparam logic [2:0] OP_ADDC = 3'h7;
   localparam logic [7:0] REG_RST = 8'h00;
   localparam int unsigned MSB = 7;
endpackage : rao_pkg

//--- design/rao_alu.sv
// combinational byte operator unit
`timescale 1ns/10ps
`default_nettype none
module rao_alu
   import rao_pkg::*;
(
   input wire logic [2:0] op_i,
   input wire logic [7:0] src_i,
   input wire logic [7:0] imm_i,
   input wire logic carry_i,
   output logic [7:0] res_o,
   output logic carry_o
);
   wire logic [8:0] sum_nc = {1'b0, src_i} + {1'b0, imm_i};
   wire logic [8:0] sum_c = sum_nc + {8'h00, carry_i};
   wire logic [7:0] shl = {src_i[MSB-1:0], carry_i};
   wire logic [7:0] shr = {carry_i, src_i[MSB:1]};
   always_comb
   begin
      res_o = imm_i;
      carry_o = carry_i;
      case (op_i)
         OP_LOAD: res_o = imm_i;
         OP_SHL:
         begin
            res_o = shl;
            carry_o = src_i[MSB];
         end
         OP_OR: res_o = src_i | imm_i;
         OP_XOR: res_o = src_i ^ imm_i;
         OP_AND: res_o = src_i & imm_i;
         OP_SHR:
         begin
            res_o = shr;
            carry_o = src_i[0];
         end
         OP_ADD:
         begin
            res_o = sum_nc[MSB:0];
            carry_o = sum_nc[MSB+1];
         end
         default:
         begin
            res_o = sum_c[MSB:0];
            carry_o = sum_c[MSB+1];
         end
      endcase
   end
endmodule : rao_alu
`default_nettype wire

//--- design/rao_top.sv
// register alu move operations: register file, scratch byte, carry
`timescale 1ns/10ps
`default_nettype none
module rao_top
   import rao_pkg::*;
(
   input wire logic mclk_i,
   input wire logic rst_n_i,
   input wire logic exec_i,
   input wire logic [2:0] opcode_i,
   input wire logic [2:0] operator_i,
   input wire logic [6:0] reg_addr_i,
   input wire logic [7:0] immediate_byte_i,
   input wire logic carry_set_i,
   input wire logic carry_clr_i,
   input wire logic [6:0] rd_addr_i,
   output logic [7:0] rd_data_o,
   output logic [7:0] scratch_compare_byte_o,
   output logic alu_carry_o,
   output logic done_o
);
   logic [7:0] regs_q [NUM_REGS];
   logic [7:0] scr_q;
   logic carry_q;
   logic done_q;
   logic [7:0] rd_q;
   logic [7:0] alu_res;
   logic alu_carry;

   // addressed register read
   wire logic [7:0] addressed_register = regs_q[reg_addr_i];
   wire logic is_rmw = opcode_i == OPC_RMW;
   wire logic is_to = opcode_i == OPC_TO_SCR;
   wire logic is_from = opcode_i == OPC_FROM_SCR;
   wire logic valid_op = is_rmw | is_to | is_from;
   wire logic go = exec_i & valid_op;
   // from-scratch uses the scratch byte as source
   wire logic [7:0] src = is_from ? scr_q : addressed_register;
   wire logic wr_reg = go & (is_rmw | is_from);
   wire logic wr_scr = go & is_to;

   rao_alu u_alu
   (
      .op_i(operator_i),
      .src_i(src),
      .imm_i(immediate_byte_i),
      .carry_i(carry_q),
      .res_o(alu_res),
      .carry_o(alu_carry)
   );

   genvar gi;
   generate
      for (gi = 0; gi < NUM_REGS; gi++)
      begin : g_reg
         always_ff @(posedge mclk_i)
         begin
            if (!rst_n_i)
               regs_q[gi] <= REG_RST;
            else if (wr_reg && reg_addr_i == 7'(gi))
               regs_q[gi] <= alu_res;
         end
      end
   endgenerate

   always_ff @(posedge mclk_i)
   begin
      if (!rst_n_i)
      begin
         scr_q <= REG_RST;
         carry_q <= 1'b0;
         done_q <= 1'b0;
         rd_q <= REG_RST;
      end
      else
      begin
         if (wr_scr)
            scr_q <= alu_res;
         if (go)
            carry_q <= alu_carry;
         else if (carry_set_i)
            carry_q <= 1'b1;
         else if (carry_clr_i)
            carry_q <= 1'b0;
         done_q <= go;
         rd_q <= regs_q[rd_addr_i];
      end
   end

   assign rd_data_o = rd_q;
   assign scratch_compare_byte_o = scr_q;
   assign alu_carry_o = carry_q;
   assign done_o = done_q;

   sequence s_add_go;
      go && operator_i == OP_ADD;
   endsequence

   // accepted instructions by routing class
   sequence s_rmw_go;
      go && is_rmw;
   endsequence

   sequence s_to_go;
      go && is_to;
   endsequence

   sequence s_from_go;
      go && is_from;
   endsequence

   AST_RMW_WB: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      (go && is_rmw) |=> regs_q[$past(reg_addr_i)] == $past(alu_res))
      else $error("rmw result not written back");
   AST_TO_KEEP: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      (go && is_to) |=> regs_q[$past(reg_addr_i)] == $past(addressed_register)
         && scr_q == $past(alu_res))
      else $error("to-scratch altered register or missed scratch");
   AST_FROM_SRC: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      (go && is_from && operator_i == OP_AND) |=>
         regs_q[$past(reg_addr_i)] == ($past(scr_q) & $past(immediate_byte_i)))
      else $error("from-scratch and wrong");
   AST_OR: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      (go && is_to && operator_i == OP_OR) |=>
         scr_q == ($past(addressed_register) | $past(immediate_byte_i)))
      else $error("or wrong");
   AST_XOR: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      (go && is_to && operator_i == OP_XOR) |=>
         scr_q == ($past(addressed_register) ^ $past(immediate_byte_i)))
      else $error("xor wrong");
   AST_LOAD: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      (go && is_to && operator_i == OP_LOAD) |=> scr_q == $past(immediate_byte_i))
      else $error("load wrong");
   AST_SHL_C: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      (go && is_to && operator_i == OP_SHL) |=>
         carry_q == $past(addressed_register[MSB]) && scr_q[0] == $past(carry_q))
      else $error("shift left carry wrong");
   AST_SHR_C: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      (go && is_to && operator_i == OP_SHR) |=>
         carry_q == $past(addressed_register[0]) && scr_q[MSB] == $past(carry_q))
      else $error("shift right carry wrong");
   AST_ADD: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      s_add_go and is_to |=> {carry_q, scr_q} ==
         {1'b0, $past(addressed_register)} + {1'b0, $past(immediate_byte_i)})
      else $error("add without carry wrong");
   AST_ADDC: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      (go && is_to && operator_i == OP_ADDC) |=> {carry_q, scr_q} ==
         {1'b0, $past(addressed_register)} + {1'b0, $past(immediate_byte_i)}
         + {8'h00, $past(carry_q)})
      else $error("add with carry wrong");
   AST_DONE: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      (exec_i && !valid_op) |=> !done_o)
      else $error("invalid opcode executed");

   // per-destination result and side-effect checks, plus done pulse, debug read and carry set checks
   AST_AND: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      (s_to_go and operator_i == OP_AND) |=>
         scr_q == ($past(addressed_register) & $past(immediate_byte_i)))
      else $error("and wrong");
   AST_SHL_RES: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      (s_rmw_go and operator_i == OP_SHL) |=>
         regs_q[$past(reg_addr_i)] == {$past(addressed_register[MSB-1:0]), $past(carry_q)})
      else $error("rmw shift left wrong");
   AST_SHR_RES: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      (s_from_go and operator_i == OP_SHR) |=>
         regs_q[$past(reg_addr_i)] == {$past(carry_q), $past(scr_q[MSB:1])}
         && carry_q == $past(scr_q[0]))
      else $error("from-scratch shift right wrong");
   AST_FROM_KEEP: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      s_from_go |=> scr_q == $past(scr_q))
      else $error("from-scratch altered scratch");
   AST_RMW_KEEP: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      s_rmw_go |=> scr_q == $past(scr_q))
      else $error("rmw altered scratch");
   AST_REFUSE_KEEP: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      (exec_i && !valid_op && !carry_set_i && !carry_clr_i) |=>
         scr_q == $past(scr_q) && carry_q == $past(carry_q)
         && regs_q[$past(reg_addr_i)] == $past(addressed_register))
      else $error("refused opcode changed state");
   AST_LOGIC_CARRY: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      (go && (operator_i == OP_LOAD || operator_i == OP_OR || operator_i == OP_XOR
         || operator_i == OP_AND)) |=> carry_q == $past(carry_q))
      else $error("logical operator changed carry");
   AST_DONE_GO: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      go |=> done_o)
      else $error("accepted instruction without done");
   AST_DONE_PULSE: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      (done_o && !go) |=> !done_o)
      else $error("done stood longer than one cycle");
   AST_RD_LAT: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      rst_n_i |=> rd_data_o == $past(regs_q[rd_addr_i]))
      else $error("debug read data wrong");
   AST_ADDC_FROM: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      (s_from_go and operator_i == OP_ADDC) |=> {carry_q, regs_q[$past(reg_addr_i)]} ==
         {1'b0, $past(scr_q)} + {1'b0, $past(immediate_byte_i)} + {8'h00, $past(carry_q)})
      else $error("from-scratch add with carry wrong");
   AST_XOR_RMW: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      (s_rmw_go and operator_i == OP_XOR) |=>
         regs_q[$past(reg_addr_i)] == ($past(addressed_register) ^ $past(immediate_byte_i)))
      else $error("rmw xor wrong");
   AST_CARRY_SET: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      (!go && carry_set_i) |=> alu_carry_o)
      else $error("carry set ignored");
   AST_ADD_RMW: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      (s_rmw_go and operator_i == OP_ADD) |=> {carry_q, regs_q[$past(reg_addr_i)]} ==
         {1'b0, $past(addressed_register)} + {1'b0, $past(immediate_byte_i)})
      else $error("rmw add without carry wrong");
endmodule : rao_top
`default_nettype wire

//--- bench/rao_top_test.sv
// self-checking bench for the register alu move operations block
`timescale 1ns/10ps
`default_nettype none
module rao_top_test import rao_pkg::*;;
   logic mclk_i = 1'b0, rst_n_i = 1'b0, exec_i = 1'b0, carry_set_i = 1'b0, carry_clr_i = 1'b0;
   logic [2:0] opcode_i = 3'h0, operator_i = 3'h0;
   logic [6:0] reg_addr_i = 7'h00, rd_addr_i = 7'h00;
   logic [7:0] immediate_byte_i = 8'h00, rd_data_o, scratch_compare_byte_o;
   logic alu_carry_o, done_o;
   logic [7:0] m_reg [NUM_REGS];
   logic [7:0] m_scr = REG_RST;
   logic m_c = 1'b0;
   int miscompares = 0, num_checks = 0;
   rao_top i_rao_top (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .exec_i(exec_i), .opcode_i(opcode_i),
      .operator_i(operator_i), .reg_addr_i(reg_addr_i), .immediate_byte_i(immediate_byte_i),
      .carry_set_i(carry_set_i), .carry_clr_i(carry_clr_i), .rd_addr_i(rd_addr_i),
      .rd_data_o(rd_data_o), .scratch_compare_byte_o(scratch_compare_byte_o),
      .alu_carry_o(alu_carry_o), .done_o(done_o));
   initial
   begin
      forever #10 mclk_i = ~mclk_i;
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         miscompares++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // one instruction; the bench model predicts every output
   task automatic run(input logic [2:0] opc, input logic [2:0] op, input logic [6:0] a,
                      input logic [7:0] d);
      logic [7:0] src;
      logic [8:0] r;
      logic ok;
      ok = (opc >= OPC_FROM_SCR);
      src = (opc == OPC_FROM_SCR) ? m_scr : m_reg[a];
      case (op)
         OP_LOAD: r = {m_c, d};
         OP_SHL: r = {src[7], src[6:0], m_c};
         OP_OR: r = {m_c, src | d};
         OP_XOR: r = {m_c, src ^ d};
         OP_AND: r = {m_c, src & d};
         OP_SHR: r = {src[0], m_c, src[7:1]};
         OP_ADD: r = {1'b0, src} + {1'b0, d};
         default: r = {1'b0, src} + {1'b0, d} + {8'h00, m_c};
      endcase
      if (ok)
      begin
         m_c = r[8];
         if (opc == OPC_TO_SCR)
            m_scr = r[7:0];
         else
            m_reg[a] = r[7:0];
      end
      opcode_i = opc;
      operator_i = op;
      reg_addr_i = a;
      rd_addr_i = a;
      immediate_byte_i = d;
      exec_i = 1'b1;
      @(negedge mclk_i);
      exec_i = 1'b0;
      chk({7'h00, done_o}, {7'h00, ok});
      chk(scratch_compare_byte_o, m_scr);
      chk({7'h00, alu_carry_o}, {7'h00, m_c});
      @(negedge mclk_i);
      chk({7'h00, done_o}, 8'h00);
      chk(rd_data_o, m_reg[a]);
   endtask : run
   task automatic setc(input logic s);
      carry_set_i = s;
      carry_clr_i = ~s;
      m_c = s;
      @(negedge mclk_i);
      carry_set_i = 1'b0;
      carry_clr_i = 1'b0;
      chk({7'h00, alu_carry_o}, {7'h00, s});
   endtask : setc
   task automatic t_rmw;
      setc(1'b1);
      for (int k = 0; k < 8; k++) run(OPC_RMW, 3'(k), 7'h7f, 8'hc3);
      $display("test rmw done");
   endtask : t_rmw
   task automatic t_to_scr;
      setc(1'b0);
      run(OPC_FROM_SCR, OP_LOAD, 7'h00, 8'ha5);
      for (int k = 0; k < 8; k++) run(OPC_TO_SCR, 3'(k), 7'h00, 8'h5a);
      $display("test to scratch done");
   endtask : t_to_scr
   task automatic t_from_scr;
      setc(1'b1);
      for (int k = 7; k >= 0; k--) run(OPC_FROM_SCR, 3'(k), 7'h11, 8'hff);
      $display("test from scratch done");
   endtask : t_from_scr
   task automatic t_refuse;
      for (int k = 0; k < 5; k++) run(3'(k), OP_LOAD, 7'h7f, 8'h99);
      $display("test refused opcodes done");
   endtask : t_refuse
   // a register used as a loop counter, counted up and then down
   task automatic t_count;
      for (int k = 0; k < 3; k++) run(OPC_RMW, OP_ADD, 7'h22, 8'h01);
      for (int k = 0; k < 4; k++) run(OPC_RMW, OP_ADD, 7'h22, 8'hff);
      $display("test loop counter done");
   endtask : t_count
   // set beats clear, an accepted instruction beats set
   task automatic t_carry_pri;
      carry_set_i = 1'b1;
      carry_clr_i = 1'b1;
      m_c = 1'b1;
      @(negedge mclk_i);
      chk({7'h00, alu_carry_o}, 8'h01);
      carry_clr_i = 1'b0;
      run(OPC_RMW, OP_ADD, 7'h33, 8'h01);
      carry_set_i = 1'b0;
      m_c = 1'b1;
      chk({7'h00, alu_carry_o}, 8'h01);
      $display("test carry priority done");
   endtask : t_carry_pri
   task automatic report_and_stop;
      $display("checks %0d miscompares %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : report_and_stop
   initial
   begin
      for (int k = 0; k < NUM_REGS; k++) m_reg[k] = REG_RST;
      repeat (2) @(negedge mclk_i);
      rst_n_i = 1'b1;
      t_to_scr();
      t_rmw();
      t_from_scr();
      t_refuse();
      t_count();
      t_carry_pri();
      report_and_stop();
   end
endmodule : rao_top_test
`default_nettype wire
